/* File: core/vpcm_defines.svh */
// Constants for the voice sample serial port: register map, field positions,
// reset values and timing figures.
// Assumes inclusion by bare name from core files; definitions only.
`ifndef VPCM_DEFINES_SVH
`define VPCM_DEFINES_SVH

// Register word offsets on the Avalon-MM slave (word index, one per register).
`define VPCM_REG_CTRL 4'h0
`define VPCM_REG_SLOT 4'h1
`define VPCM_REG_TXD0 4'h2
`define VPCM_REG_TXD1 4'h3
`define VPCM_REG_TXD2 4'h4
`define VPCM_REG_RXD0 4'h5
`define VPCM_REG_RXD1 4'h6
`define VPCM_REG_RXD2 4'h7
`define VPCM_REG_STAT 4'h8

// Control register fields.
`define VPCM_C_MASTER 0
`define VPCM_C_FMT_LO 1
`define VPCM_C_FMT_HI 2
`define VPCM_C_FRM_LO 3
`define VPCM_C_FRM_HI 4
`define VPCM_C_SLOT16 5
`define VPCM_C_LSBF 6
`define VPCM_C_PAD_LO 7
`define VPCM_C_PAD_HI 8
`define VPCM_C_ATT_LO 9
`define VPCM_C_ATT_HI 11
`define VPCM_C_MUTE 12
`define VPCM_C_SYNCOFF 13
`define VPCM_C_RELRISE 14
`define VPCM_C_RATE_LO 15
`define VPCM_C_RATE_HI 16
`define VPCM_C_HIRATE 17
`define VPCM_C_LONG16 18
`define VPCM_C_EN 19
`define VPCM_CTRL_RST 20'h00000
`define VPCM_CTRL_W 20

// Slot register: per connection an enable bit and a two-bit slot number.
`define VPCM_SLOT_RST 9'h000
`define VPCM_SLOT_W 9

// Master clock half periods in system clocks: 100 MHz over 2*rate.
`define VPCM_CLK_HZ 100000000
`define VPCM_HALF_128 10'((`VPCM_CLK_HZ / (2 * 128000)))
`define VPCM_HALF_256 10'((`VPCM_CLK_HZ / (2 * 256000)))
`define VPCM_HALF_512 10'((`VPCM_CLK_HZ / (2 * 512000)))
`define VPCM_HALF_HI 10'((`VPCM_CLK_HZ / (2 * 2048000)))
// Bit clocks per 8 kHz frame for each rate.
`define VPCM_FRAME_128 9'd16
`define VPCM_FRAME_256 9'd32
`define VPCM_FRAME_512 9'd64
`define VPCM_FRAME_HI 9'd256
`define VPCM_LONG_LEN8 9'd8
`define VPCM_LONG_LEN16 9'd16

`endif

/* File: core/vpcm_mclk.sv */
// Master role bit clock and frame strobe generator.
// Assumes a 100 MHz clk; rate and strobe style come from the control word.
`timescale 1ns/1ps
`include "vpcm_defines.svh"
module vpcm_mclk
   import vpcm_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [1:0] rate,
   input wire logic hirate,
   input wire logic long16,
   input wire vpcm_frm_t frm,
   input wire logic sync_off,
   output logic bclk_q,
   output logic fs_q
);
   logic [9:0] div_q;
   logic [8:0] bit_q;
   wire [9:0] half_w = hirate ? `VPCM_HALF_HI : (rate == 2'h0) ? `VPCM_HALF_128 :
                       (rate == 2'h1) ? `VPCM_HALF_256 : `VPCM_HALF_512;
   wire [8:0] frame_w = hirate ? `VPCM_FRAME_HI : (rate == 2'h0) ? `VPCM_FRAME_128 :
                        (rate == 2'h1) ? `VPCM_FRAME_256 : `VPCM_FRAME_512;
   wire [8:0] long_w = (hirate && long16) ? `VPCM_LONG_LEN16 : `VPCM_LONG_LEN8;
   wire half_end = (div_q == half_w - 10'h001);
   wire fall_now = half_end && bclk_q;
   // Strobe changes on the falling bit clock edge so it is stable at the next rise.
   wire [8:0] nbit = (bit_q == frame_w - 9'h001) ? 9'h000 : bit_q + 9'h001;
   wire fs_long = (nbit < long_w);
   wire fs_short = (nbit == frame_w - 9'h001);
   wire fs_next = !sync_off && ((frm == VPCM_FRM_SHORT) ? fs_short :
                  (frm == VPCM_FRM_GCI) ? (nbit == 9'h000) : fs_long);

   // Free running divider; one strobe per frame of frame_w bits.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= 10'h000;
         bclk_q <= 1'b0;
         bit_q <= 9'h000;
         fs_q <= 1'b0;
      end else if (!run) begin
         div_q <= 10'h000;
         bclk_q <= 1'b0;
         bit_q <= 9'h000;
         fs_q <= 1'b0;
      end else begin
         div_q <= half_end ? 10'h000 : div_q + 10'h001;
         if (half_end) begin
            bclk_q <= !bclk_q;
         end
         if (fall_now) begin
            bit_q <= nbit;
         end
         // Suppression drops the strobe at once, not a bit clock later.
         fs_q <= fall_now ? fs_next : (fs_q && !sync_off);
      end
   end
endmodule : vpcm_mclk

/* File: core/vpcm_pkg.sv */
// Types shared by the voice sample serial port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package vpcm_pkg;
   typedef enum logic [1:0] {VPCM_FMT_LIN13 = 2'h0, VPCM_FMT_LIN16 = 2'h1,
                             VPCM_FMT_ULAW = 2'h2, VPCM_FMT_ALAW = 2'h3} vpcm_fmt_t;
   typedef enum logic [1:0] {VPCM_FRM_LONG = 2'h0, VPCM_FRM_SHORT = 2'h1,
                             VPCM_FRM_GCI = 2'h2} vpcm_frm_t;
   typedef enum logic [1:0] {VPCM_PAD_SIGN = 2'h0, VPCM_PAD_ZERO = 2'h1,
                             VPCM_PAD_ATT = 2'h2} vpcm_pad_t;
   typedef enum logic [2:0] {VPCM_ST_IDLE = 3'h1, VPCM_ST_SLOT = 3'h2,
                             VPCM_ST_GAP = 3'h4} vpcm_st_t;
endpackage : vpcm_pkg

/* File: core/vpcm_port.sv */
// Voice sample serial port: Avalon-MM register slave plus serial engine.
// Assumes pins are asynchronous to clk and are synchronised here.
//
// Function
// - Master drives bit clock and strobe at 128, 256, 512 or 2048 kHz.
// - Slave works with any supplied bit clock up to 2048 kHz.
// - Long frame sync: rising strobe starts a sample word.
// - Master long frame strobe stays high eight bit clocks, or 16 at high rate with long16 set.
// - Input sampled on falling bit clock, output launched on rising.
// - Output released after last bit, at LSB falling or next rising edge.
// - Short frame sync: falling strobe starts word; pulse one bit long.
// - Three connections, each on any of the first four slots.
// - GCI: rising strobe starts each 8 kHz frame.
// - Slave in GCI accepts bit clock up to 4.096 MHz.
// - GCI gives access to both 64 kbit/s bearer channels.
// - Slots are 8 or 16 bits; 8-bit slots only for 8-bit formats.
// - Formats: 13-bit, 16-bit linear, 8-bit mu-law or A-law.
// - Bit order selectable MSB first or LSB first.
// - Unused slot bits: sign extension, zeros or 3-bit attenuation.
// - Mute drives serial output constantly low.
// - Master may hold strobe low while bit clock keeps running.
// - High-rate master long strobe length selectable as 8 or 16.
`timescale 1ns/1ps
`include "vpcm_defines.svh"
module vpcm_port
   import vpcm_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pcm_clk_i,
   output logic pcm_clk_o,
   output logic pcm_clk_oe,
   input wire logic pcm_sync_i,
   output logic pcm_sync_o,
   output logic pcm_sync_oe,
   input wire logic pcm_in,
   output logic pcm_out_o,
   output logic pcm_out_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // Register file.
   logic [`VPCM_CTRL_W-1:0] ctrl_q;
   logic [`VPCM_SLOT_W-1:0] slot_q;
   logic [15:0] txd_q [3];
   logic [15:0] rxd_q [3];
   logic [2:0] rxnew_q;
   logic [2:0] txtaken_q;
   logic ack_q;
   logic [31:0] rdata_q;

   wire master = ctrl_q[`VPCM_C_MASTER];
   wire en = ctrl_q[`VPCM_C_EN];
   wire vpcm_fmt_t fmt = vpcm_fmt_t'(ctrl_q[`VPCM_C_FMT_HI:`VPCM_C_FMT_LO]);
   wire vpcm_frm_t frm = vpcm_frm_t'(ctrl_q[`VPCM_C_FRM_HI:`VPCM_C_FRM_LO]);
   wire vpcm_pad_t pad = vpcm_pad_t'(ctrl_q[`VPCM_C_PAD_HI:`VPCM_C_PAD_LO]);
   wire [2:0] att = ctrl_q[`VPCM_C_ATT_HI:`VPCM_C_ATT_LO];
   wire lsbf = ctrl_q[`VPCM_C_LSBF];
   wire mute = ctrl_q[`VPCM_C_MUTE];
   wire rel_rise = ctrl_q[`VPCM_C_RELRISE];
   wire is8 = (fmt == VPCM_FMT_ULAW) || (fmt == VPCM_FMT_ALAW);
   // Eight-bit slots make no sense for linear formats, so they are forced to 16.
   wire slot16 = ctrl_q[`VPCM_C_SLOT16] || !is8 || (frm == VPCM_FRM_GCI);

   wire req = avs_read || avs_write;
   // A write lands at the edge where the master sees waitrequest low.
   wire wr_go = avs_write && ack_q;
   wire rd_go = avs_read && !ack_q;
   wire [1:0] rx_idx = 2'(avs_address - `VPCM_REG_RXD0);
   wire [1:0] tx_idx = 2'(avs_address - `VPCM_REG_TXD0);
   wire is_rx = (avs_address >= `VPCM_REG_RXD0) && (avs_address <= `VPCM_REG_RXD2);
   wire is_tx = (avs_address >= `VPCM_REG_TXD0) && (avs_address <= `VPCM_REG_TXD2);
   wire [31:0] rd_mux = (avs_address == `VPCM_REG_CTRL) ? 32'(ctrl_q) :
                        (avs_address == `VPCM_REG_SLOT) ? 32'(slot_q) :
                        is_tx ? 32'(txd_q[tx_idx]) :
                        is_rx ? 32'(rxd_q[rx_idx]) :
                        (avs_address == `VPCM_REG_STAT) ? {26'h0, txtaken_q, rxnew_q} :
                        32'h0000_0000;

   // One wait state: the answer comes at the second edge of a request.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= req && !ack_q;
         avs_waitrequest <= !(req && !ack_q);
         if (rd_go) begin
            rdata_q <= rd_mux;
         end
      end
   end
   assign avs_readdata = rdata_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= `VPCM_CTRL_RST;
         slot_q <= `VPCM_SLOT_RST;
         txd_q <= '{default: 16'h0000};
      end else if (wr_go && is_tx) begin
         txd_q[tx_idx] <= avs_writedata[15:0];
      end else if (wr_go && avs_address == `VPCM_REG_CTRL) begin
         ctrl_q <= avs_writedata[`VPCM_CTRL_W-1:0];
      end else if (wr_go && avs_address == `VPCM_REG_SLOT) begin
         slot_q <= avs_writedata[`VPCM_SLOT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and master generator.
   logic clk_s, sync_s, in_s, clk_d1_q, sync_d1_q;
   logic m_bclk, m_fs;
   vpcm_sync2 u_sclk (.clk(clk), .sys_rst(sys_rst), .d(pcm_clk_i), .q(clk_s));
   vpcm_sync2 u_ssync (.clk(clk), .sys_rst(sys_rst), .d(pcm_sync_i), .q(sync_s));
   vpcm_sync2 u_sin (.clk(clk), .sys_rst(sys_rst), .d(pcm_in), .q(in_s));
   vpcm_mclk u_mclk (
      .clk(clk), .sys_rst(sys_rst), .run(en && master),
      .rate(ctrl_q[`VPCM_C_RATE_HI:`VPCM_C_RATE_LO]), .hirate(ctrl_q[`VPCM_C_HIRATE]),
      .long16(ctrl_q[`VPCM_C_LONG16]), .frm(frm), .sync_off(ctrl_q[`VPCM_C_SYNCOFF]),
      .bclk_q(m_bclk), .fs_q(m_fs)
   );

   // Master drives both pins; a slave reads the synchronised pins.
   // The slave limit of 2048 kHz (4096 in GCI) keeps each phase over 10 clocks.
   wire bclk = master ? m_bclk : clk_s;
   wire fsync = master ? m_fs : sync_s;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clk_d1_q <= 1'b0;
         sync_d1_q <= 1'b0;
         pcm_clk_o <= 1'b0;
         pcm_clk_oe <= 1'b0;
         pcm_sync_o <= 1'b0;
         pcm_sync_oe <= 1'b0;
      end else begin
         clk_d1_q <= bclk;
         sync_d1_q <= fsync;
         pcm_clk_o <= m_bclk;
         pcm_clk_oe <= en && master;
         pcm_sync_o <= m_fs;
         pcm_sync_oe <= en && master;
      end
   end
   wire rise = bclk && !clk_d1_q;
   wire fall = !bclk && clk_d1_q;

   ////////////////////////////////////////////////////////////////////////////
   // Frame and slot tracking. The strobe is seen at a falling bit clock edge;
   // the first data bit is the next rise (long, GCI) or the rise after the
   // falling strobe edge (short).
   logic fs_prev_q;
   logic [4:0] bit_q;
   logic [2:0] slot_idx_q;
   vpcm_st_t st_q;
   wire fs_start = (frm == VPCM_FRM_SHORT) ? (fs_prev_q && !fsync) :
                   (!fs_prev_q && fsync);
   wire [4:0] slot_last = slot16 ? 5'd15 : 5'd7;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fs_prev_q <= 1'b0;
         bit_q <= 5'h00;
         slot_idx_q <= 3'h0;
         st_q <= VPCM_ST_IDLE;
      end else if (!en) begin
         st_q <= VPCM_ST_IDLE;
      end else if (fall) begin
         fs_prev_q <= fsync;
         // A strobe always restarts the frame, so short frames stay aligned.
         if (fs_start) begin
            st_q <= VPCM_ST_SLOT;
            bit_q <= 5'h1f; // Bumped to zero at the first sampled bit.
            slot_idx_q <= 3'h0;
         end else begin
            unique case (st_q)
               VPCM_ST_IDLE, VPCM_ST_GAP: begin
                  st_q <= st_q;
               end
               VPCM_ST_SLOT: begin
                  if (nbit == slot_last) begin
                     bit_q <= 5'h1f;
                     slot_idx_q <= slot_idx_q + 3'h1;
                     if (slot_idx_q == 3'h3) begin
                        st_q <= VPCM_ST_GAP;
                     end
                  end else begin
                     bit_q <= nbit;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slot matching and sample formatting.
   function automatic logic [1:0] vpcm_match(input logic [8:0] s, input logic [1:0] sl);
      logic [1:0] r;
      r = 2'h3;
      for (int i = 2; i >= 0; i--) begin
         if (s[3*i+2] && s[3*i+:2] == sl) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction : vpcm_match

   // Build the 16-bit slot image, MSB at bit 15.
   function automatic logic [15:0] vpcm_frame(input logic [15:0] d, input vpcm_fmt_t f,
                                              input vpcm_pad_t p, input logic [2:0] a);
      logic [15:0] r;
      r = d;
      if (f == VPCM_FMT_LIN13) begin
         r = {d[12:0], (p == VPCM_PAD_ATT) ? a : 3'h0};
      end else if (f != VPCM_FMT_LIN16) begin
         r = {d[7:0], (p == VPCM_PAD_SIGN) ? {8{d[7]}} : 8'h00};
      end
      if (f == VPCM_FMT_LIN13 && p == VPCM_PAD_SIGN) begin
         r = {d[12:0], {3{d[12]}}};
      end
      return r;
   endfunction : vpcm_frame

   wire in_slot = (st_q == VPCM_ST_SLOT) && (slot_idx_q < 3'h4);
   wire [1:0] conn = vpcm_match(slot_q, slot_idx_q[1:0]);
   wire active = in_slot && (conn != 2'h3);
   wire [15:0] img = vpcm_frame(txd_q[conn == 2'h3 ? 2'h0 : conn], fmt, pad, att);
   wire [4:0] nbit = bit_q + 5'h01;
   wire [3:0] span = slot16 ? 4'hf : 4'h7;
   wire [3:0] pos = lsbf ? 4'(span - 4'(nbit)) : 4'(nbit);
   wire [3:0] sel = 4'hf - (slot16 ? pos : 4'(pos)); // 8-bit slots use img[15:8].
   wire last_bit = (nbit == slot_last);
   wire launch = rise && in_slot;
   wire release_now = (rise && rel_rise) || (fall && last_bit && !rel_rise);

   // Mute acts at once so a bit launched before it cannot linger on the pin.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pcm_out_o <= 1'b0;
         pcm_out_oe <= 1'b0;
      end else if (!en) begin
         pcm_out_oe <= 1'b0;
      end else if (launch) begin
         pcm_out_o <= mute ? 1'b0 : img[sel];
         pcm_out_oe <= active;
      end else begin
         if (mute) begin
            pcm_out_o <= 1'b0;
         end
         if (release_now) begin
            pcm_out_oe <= 1'b0;
         end
      end
   end

   // Receive shifter; flags are set at the last bit and cleared by a status read.
   logic [15:0] sh_q;
   wire [15:0] sh_d = lsbf ? {in_s, sh_q[15:1]} : {sh_q[14:0], in_s};
   wire stat_rd = rd_go && (avs_address == `VPCM_REG_STAT);
   wire take = en && fall && active && !fs_start;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sh_q <= 16'h0000;
         rxd_q <= '{default: 16'h0000};
         rxnew_q <= 3'h0;
         txtaken_q <= 3'h0;
      end else begin
         if (stat_rd) begin
            rxnew_q <= 3'h0;
            txtaken_q <= 3'h0;
         end
         if (take) begin
            sh_q <= sh_d;
            if (last_bit) begin
               rxd_q[conn] <= sh_d;
               rxnew_q[conn] <= 1'b1;
               txtaken_q[conn] <= 1'b1;
            end
         end
      end
   end
endmodule : vpcm_port

/* File: core/vpcm_sync2.sv */
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the input holds each level for more than two clocks.
`timescale 1ns/1ps
module vpcm_sync2 (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic d,
   output logic q
);
   logic meta_q;

   // First stage feeds only the second stage.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : vpcm_sync2

/* File: tb/vpcm_codec_model.sv */
// Far-side codec model: bit clock master, long strobe, word in slot 0.
// Assumes the port is slave with 16-bit slots; 32 bit clocks a frame.
`timescale 1ns/1ps
module vpcm_codec_model (
   input wire logic run,
   input wire logic [15:0] tx_word,
   input wire logic dev_out,
   input wire logic dev_out_oe,
   output logic bclk,
   output logic sync,
   output logic din,
   output logic [15:0] rx_word,
   output int frames
);
   logic [4:0] bc = 5'h0;
   logic [15:0] sh = 16'h0;
   initial begin
      bclk = 1'b0;
      sync = 1'b0;
      din = 1'b0;
      rx_word = 16'h0;
      frames = 0;
   end
   // The clock stands still between runs.
   always begin
      #40;
      bclk = run ? ~bclk : 1'b0;
   end
   // Data bits change on the rising bit clock edge.
   always @(posedge bclk) begin
      bc <= bc + 5'h1;
      din <= bc < 5'h10 ? tx_word[4'hf - bc[3:0]] : ~din;
      frames <= frames + int'(bc == 5'h0);
   end
   // Strobe rises at the fall before the first bit and spans eight bits.
   // Inside its slot the port must drive, as bits seen without its enable are skipped and spoil the word.
   always @(negedge bclk) begin
      sync <= bc < 5'h8;
      if (bc >= 5'h1 && bc <= 5'h10 && dev_out_oe) begin
         sh <= {sh[14:0], dev_out};
         if (bc == 5'h10) rx_word <= {sh[14:0], dev_out};
      end
   end
endmodule : vpcm_codec_model

/* File: tb/vpcm_port_assertions.sv */
// Checker for the voice sample port, bound to its top ports.
// Assumes a 100 MHz clk and the control word written over Avalon.
`timescale 1ns/1ps
`include "vpcm_defines.svh"
module vpcm_port_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic pcm_clk_o,
   input wire logic pcm_clk_oe,
   input wire logic pcm_sync_o,
   input wire logic pcm_sync_oe,
   input wire logic pcm_out_o,
   input wire logic pcm_out_oe
);
   logic [19:0] ctrl_q;
   logic [3:0] age_q;
   logic [1:0] nsr_q;
   logic clk_d_q;
   logic sync_d_q;
   logic [10:0] cnt_q;
   logic [10:0] per_q;
   logic [14:0] hi_q;
   logic [14:0] frm_q;
   // All checks but a_bus_wait wait until a new control word has stood a while.
   wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == `VPCM_REG_CTRL;
   wire clk_up = pcm_clk_o && !clk_d_q;
   wire sync_up = pcm_sync_o && !sync_d_q;
   wire aged = age_q == 4'hf;
   wire settled = aged && ctrl_q[`VPCM_C_EN];
   wire mst = settled && ctrl_q[`VPCM_C_MASTER];
   wire is_short = ctrl_q[`VPCM_C_FRM_HI:`VPCM_C_FRM_LO] == 2'h1;
   wire [14:0] flen = (ctrl_q[`VPCM_C_HIRATE] && ctrl_q[`VPCM_C_LONG16]) ? 15'h10 : 15'h8;
   wire [14:0] want_hi = is_short ? 15'(per_q) : flen * 15'(per_q);
   // Control copy, its age, and strobes seen since it changed.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= `VPCM_CTRL_RST;
         age_q <= 4'h0;
         nsr_q <= 2'h0;
      end else begin
         ctrl_q <= ctrl_wr ? avs_writedata[19:0] : ctrl_q;
         age_q <= ctrl_wr ? 4'h0 : age_q + 4'(!aged);
         nsr_q <= ctrl_wr ? 2'h0 : nsr_q + 2'(sync_up && nsr_q != 2'h3);
      end
   end
   // Bit clock period, strobe width and frame length in clk cycles.
   always_ff @(posedge clk) begin
      clk_d_q <= pcm_clk_o;
      sync_d_q <= pcm_sync_o;
      cnt_q <= clk_up ? 11'h0 : cnt_q + 11'h1;
      per_q <= clk_up ? cnt_q + 11'h1 : per_q;
      hi_q <= sync_up ? 15'h1 : hi_q + 15'(pcm_sync_o);
      frm_q <= sync_up ? 15'h1 : frm_q + 15'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_bus_wait: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("Bus answer not at second edge.");
   a_master_drives: assert property (
      mst |-> pcm_clk_oe && pcm_sync_oe) else $error("Master pins not driven.");
   a_slave_listens: assert property (
      settled && !ctrl_q[`VPCM_C_MASTER] |-> !pcm_clk_oe && !pcm_sync_oe)
      else $error("Slave drives clock or strobe.");
   a_mute_low: assert property (
      settled && ctrl_q[`VPCM_C_MUTE] && pcm_out_oe |-> !pcm_out_o)
      else $error("Muted output not low.");
   a_sync_held: assert property (
      mst && ctrl_q[`VPCM_C_SYNCOFF] |-> !pcm_sync_o) else $error("Strobe not held low.");
   a_idle_hiz: assert property (
      aged && !ctrl_q[`VPCM_C_EN] |-> !pcm_out_oe) else $error("Idle port drives output.");
   a_launch_rise: assert property (
      mst && pcm_out_oe && $past(pcm_out_oe) && pcm_out_o != $past(pcm_out_o)
      |-> clk_up || cnt_q < 11'd6) else $error("Output bit not launched at rise.");
   a_strobe_len: assert property (
      mst && nsr_q[1] && !ctrl_q[`VPCM_C_FRM_HI] && $fell(pcm_sync_o)
      |-> hi_q + 15'd4 >= want_hi && hi_q <= want_hi + 15'd4)
      else $error("Strobe width wrong.");
   a_frame_rate: assert property (
      mst && nsr_q != 2'h0 && sync_up |-> frm_q > 15'd12375 && frm_q < 15'd12625)
      else $error("Frame period wrong.");
endmodule : vpcm_port_assertions

bind vpcm_port vpcm_port_assertions vpcm_port_assertions_i (.clk(clk), .sys_rst(sys_rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .pcm_clk_o(pcm_clk_o), .pcm_clk_oe(pcm_clk_oe), .pcm_sync_o(pcm_sync_o),
   .pcm_sync_oe(pcm_sync_oe), .pcm_out_o(pcm_out_o), .pcm_out_oe(pcm_out_oe));

/* File: tb/vpcm_port_test.sv */
// Self-checking bench for the voice sample port with a codec model.
// Assumes the port answers an Avalon access at its second edge.
`timescale 1ns/1ps
`include "vpcm_defines.svh"
`define CHK(nm, ex, got) \
   begin \
      n_tests++; \
      if ((got) !== (ex)) begin \
         mismatches++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      end \
   end
module vpcm_port_test;
   localparam logic [31:0] BASE = (32'h1 << `VPCM_C_EN) | (32'h1 << `VPCM_C_FMT_LO)
      | (32'h1 << `VPCM_C_SLOT16);
   localparam logic [31:0] MST = (32'h1 << `VPCM_C_MASTER) | (32'h2 << `VPCM_C_RATE_LO);
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, pcm_clk_o, pcm_clk_oe, pcm_sync_o, pcm_sync_oe;
   logic pcm_out_o, pcm_out_oe, m_bclk, m_sync, m_din;
   logic m_run = 1'b0;
   logic [15:0] m_rx;
   int m_frames;
   int mismatches = 0;
   int n_tests = 0;
   int half_tab [3] = '{`VPCM_HALF_128, `VPCM_HALF_256, `VPCM_HALF_512};
   // Each shared pin carries whichever party has its enable up.
   wire pclk = pcm_clk_oe ? pcm_clk_o : m_bclk;
   wire psync = pcm_sync_oe ? pcm_sync_o : m_sync;
   always #5 clk = ~clk;
   vpcm_port vpcm_port_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pcm_clk_i(pclk),
      .pcm_clk_o(pcm_clk_o), .pcm_clk_oe(pcm_clk_oe), .pcm_sync_i(psync),
      .pcm_sync_o(pcm_sync_o), .pcm_sync_oe(pcm_sync_oe), .pcm_in(m_din),
      .pcm_out_o(pcm_out_o), .pcm_out_oe(pcm_out_oe));
   vpcm_codec_model vpcm_codec_model_i (.run(m_run), .tx_word(16'h3c96), .dev_out(pcm_out_o),
      .dev_out_oe(pcm_out_oe), .bclk(m_bclk), .sync(m_sync), .din(m_din), .rx_word(m_rx),
      .frames(m_frames));
   // Avalon master: request held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 50) `CHK("bus answer", 1'b1, 1'b0)
   endtask : bus
   task automatic clk_rise(output int c);
      logic prev;
      c = 0;
      do begin
         prev = pcm_clk_o;
         @(posedge clk);
         c++;
      end while (!(pcm_clk_o === 1'b1 && prev === 1'b0) && c < 2000);
   endtask : clk_rise
   task automatic until_sync(input logic lvl, inout int c);
      while (pcm_sync_o !== lvl && c < 40000) begin
         @(posedge clk);
         c++;
      end
   endtask : until_sync
   // Frame length, then the width of the next whole strobe.
   task automatic frame_watch(output int hi, output int fr);
      int n;
      n = 0;
      until_sync(1'b0, n);
      until_sync(1'b1, n);
      fr = n;
      until_sync(1'b0, n);
      until_sync(1'b1, n);
      fr = n - fr;
      hi = n;
      until_sync(1'b0, n);
      hi = n - hi;
      `CHK("frame length ok", 1'b1, fr > 12375 && fr < 12625)
   endtask : frame_watch
   task automatic wait_frames(input int k);
      int f0;
      int n;
      f0 = m_frames;
      n = 0;
      while (m_frames < f0 + k && n < 20000) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_frames
   task automatic t_regs;
      logic [31:0] r;
      bus(1'b0, `VPCM_REG_CTRL, 32'h0, r);
      `CHK("ctrl reset", 32'(`VPCM_CTRL_RST), r)
      bus(1'b0, `VPCM_REG_SLOT, 32'h0, r);
      `CHK("slot reset", 32'(`VPCM_SLOT_RST), r)
      bus(1'b1, `VPCM_REG_SLOT, 32'h4, r);
      bus(1'b0, `VPCM_REG_SLOT, 32'h0, r);
      `CHK("slot readback", 32'h4, r)
      bus(1'b0, 4'hf, 32'h0, r);
      `CHK("unmapped read", 32'h0, r)
   endtask : t_regs
   // Master rates 128, 256 and 512 kHz, then long strobe width at 512 kHz.
   task automatic t_rates;
      logic [31:0] r;
      int c;
      int hi;
      int fr;
      bus(1'b1, `VPCM_REG_TXD0, 32'h0000b2d4, r);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, `VPCM_REG_CTRL, BASE | 32'h1 | (32'(k) << `VPCM_C_RATE_LO), r);
         clk_rise(c);
         clk_rise(c);
         `CHK("bit clock period", 2 * half_tab[k], c)
      end
      frame_watch(hi, fr);
      `CHK("long strobe ok", 1'b1, hi >= 8 * c - 4 && hi <= 8 * c + 4)
   endtask : t_rates
   task automatic t_short;
      logic [31:0] r;
      int c;
      int hi;
      int fr;
      bus(1'b1, `VPCM_REG_CTRL, BASE | MST | (32'h1 << `VPCM_C_FRM_LO)
         | (32'h1 << `VPCM_C_MUTE), r);
      clk_rise(c);
      clk_rise(c);
      frame_watch(hi, fr);
      `CHK("short strobe ok", 1'b1, hi >= c - 4 && hi <= c + 4)
   endtask : t_short
   task automatic t_syncoff;
      logic [31:0] r;
      logic prev;
      int n_hi;
      int n_up;
      bus(1'b1, `VPCM_REG_CTRL, BASE | MST | (32'h1 << `VPCM_C_SYNCOFF), r);
      repeat (20) @(posedge clk);
      n_hi = 0;
      n_up = 0;
      prev = pcm_clk_o;
      repeat (7000) begin
         @(posedge clk);
         n_hi += int'(pcm_sync_o !== 1'b0);
         n_up += int'(pcm_clk_o === 1'b1 && prev === 1'b0);
         prev = pcm_clk_o;
      end
      `CHK("strobe highs", 0, n_hi)
      `CHK("clock runs", 1'b1, n_up > 30)
   endtask : t_syncoff
   // Slave on the model's clock, both bit orders, both directions.
   task automatic t_slave;
      logic [31:0] r;
      bus(1'b1, `VPCM_REG_TXD0, 32'h0000a5c3, r);
      bus(1'b1, `VPCM_REG_CTRL, BASE, r);
      m_run <= 1'b1;
      wait_frames(5);
      `CHK("codec word", 16'ha5c3, m_rx)
      bus(1'b0, `VPCM_REG_RXD0, 32'h0, r);
      `CHK("port word", 16'h3c96, r[15:0])
      bus(1'b1, `VPCM_REG_CTRL, BASE | (32'h1 << `VPCM_C_LSBF), r);
      wait_frames(4);
      `CHK("codec word lsb", 16'hc3a5, m_rx)
      bus(1'b0, `VPCM_REG_RXD0, 32'h0, r);
      `CHK("port word lsb", 16'h693c, r[15:0])
      m_run <= 1'b0;
      bus(1'b1, `VPCM_REG_CTRL, 32'h0, r);
      repeat (20) @(posedge clk);
      `CHK("output released", 1'b0, pcm_out_oe)
   endtask : t_slave
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_rates();
      t_short();
      t_syncoff();
      t_slave();
      wrap_up();
   end
   // Watchdog sized a little above the longest expected run.
   initial begin
      #900000;
      mismatches++;
      wrap_up();
   end
endmodule : vpcm_port_test
